// ### psa_pkg.sv
// Purpose: Shared constants and types for the supply alarm supervisor
// Assumes: 20 MHz mclk, AHB-Lite register access
// Notes: All timing figures are kept in their own unit; only the ms tick length is derived here
package psa_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned SAFETY_DELAY_MS = 2000;
  localparam int unsigned SOFT_TO_MAIN_MS = 2000;
  localparam int unsigned MAIN_TO_REL_MS = 1000;
  localparam int unsigned BLOWER_RUN_S = 240;
  localparam int unsigned DEBOUNCE_MS = 10;
  // Millisecond tick derived from the clock rate
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_INPUTS = 8'h0c;

  // Control register field positions
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_DUAL_BIT = 1;
  localparam int unsigned CTRL_MANUAL_BIT = 2;
  localparam int unsigned CTRL_ARESET_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Event bit positions in the event and input registers
  localparam int unsigned EV_MAINS = 0;
  localparam int unsigned EV_AIR = 1;
  localparam int unsigned EV_BLOWER = 2;
  localparam int unsigned EV_FUSE_A = 3;
  localparam int unsigned EV_HEAT_A = 4;
  localparam int unsigned EV_FUSE_B = 5;
  localparam int unsigned EV_HEAT_B = 6;
  localparam int unsigned EV_SAFETY = 7;
  localparam int unsigned NUM_IN = 8;

  // Power-up sequence states
  typedef enum logic [2:0] {
    PSA_OFF,
    PSA_SOFT,
    PSA_MAIN,
    PSA_RUN
  } psa_seq_t;

  // Outcome severity
  typedef enum logic [1:0] {
    PSA_SEV_NONE,
    PSA_SEV_WARN,
    PSA_SEV_WAIT,
    PSA_SEV_FAULT
  } psa_sev_t;

  // Contactor and line outputs grouped
  typedef struct packed {
    logic feed_en;
    logic soft_k;
    logic main_k;
    logic blower_k;
    logic exciter_en;
    logic rf_mute_line;
    logic alarm_line_n;
    logic warn_led;
  } psa_out_t;

endpackage

// ### psa_supervisor.sv
// Purpose: Supervisor for the transmitter power supply section
// Assumes: One 20 MHz clock, synchronous active-low reset, AHB-Lite slave
// Notes: Protection inputs are asynchronous pins, active high alarms
//
// Summary of operation
// - Emergency stop cuts contactor feed at once
// - Exciter stays enabled during emergency stop
// - Emergency stop reported via status and alarm
// - Auto mode restarts two seconds after release
// - Manual mode waits for safety reset button
// - Emergency stop never logged as event
// - Mains alarm opens soft and main contactors and stops exciters; blower runs on
// - Mains recovery restarts automatically
// - Each mains alarm is logged
// - Air fault opens transformer contactors temporarily
// - Air recovery restarts, each fault logged
// - Blower trip latches fault state
// - Fault cleared by rearm plus reset command
// - Single carriage: carriage alarm stops equipment
// - Dual carriage: keep running, light warning
// - Fuse input is whole interlock chain
// - Overheat input holds equipment temporarily
// - Overheat clear restarts, each occurrence logged
// - Second carriage handled like the first
// - All alarm input states readable by control unit
// - Soft start, main after 2s, release 1s
// - Any alarm pulls shared alarm line low
// - Blower runs four minutes after any stop
`timescale 1ns/1ps
module psa_supervisor #(
  parameter int unsigned DEB_MS = psa_pkg::DEBOUNCE_MS,
  parameter int unsigned BLOWER_S = psa_pkg::BLOWER_RUN_S,
  parameter int unsigned MS_CYC = psa_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Protection inputs, high means alarm
  input wire logic safety_alarm,
  input wire logic safety_reset_btn,
  input wire logic mains_alarm,
  input wire logic air_alarm,
  input wire logic blower_trip,
  input wire logic carriage_a_fuse,
  input wire logic carriage_a_overheat,
  input wire logic carriage_b_fuse,
  input wire logic carriage_b_overheat,
  // Actuators and bus lines
  output psa_pkg::psa_out_t outs
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and debouncers

  // Raw pins gathered in event bit order
  logic [psa_pkg::NUM_IN-1:0] pin_raw;
  logic [psa_pkg::NUM_IN-1:0] sync1_r;
  logic [psa_pkg::NUM_IN-1:0] sync2_r;
  logic [psa_pkg::NUM_IN-1:0] deb_r;
  logic [1:0] btn_sync_r;
  logic btn_deb_r;
  // Millisecond tick keeps the debounce counters short
  logic [15:0] ms_cnt_r;
  logic ms_tick_r;

  assign pin_raw = {safety_alarm, carriage_b_overheat, carriage_b_fuse,
                    carriage_a_overheat, carriage_a_fuse, blower_trip,
                    air_alarm, mains_alarm};

  // Two-stage synchroniser; first stage only feeds the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      btn_sync_r <= 2'h0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      btn_sync_r <= {btn_sync_r[0], safety_reset_btn};
    end
  end

  // Divider producing a one-cycle enable per millisecond
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == 16'(MS_CYC - 1)) begin
      ms_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 16'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  // One debouncer per alarm input: level must hold DEB_MS ticks to be taken
  genvar gi;
  generate
    for (gi = 0; gi < psa_pkg::NUM_IN; gi++) begin : g_deb
      logic [7:0] cnt_r;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cnt_r <= 8'h00;
          deb_r[gi] <= 1'b0;
        end else if (sync2_r[gi] == deb_r[gi]) begin
          cnt_r <= 8'h00;
        end else if (ms_tick_r) begin
          if (cnt_r == 8'(DEB_MS - 1)) begin
            deb_r[gi] <= sync2_r[gi];
            cnt_r <= 8'h00;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
      end
    end
  endgenerate

  // Button only needs synchronising; it is an edge-insensitive level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      btn_deb_r <= 1'b0;
    end else begin
      btn_deb_r <= btn_sync_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] ctrl_r;
  logic [31:0] event_r;
  logic [psa_pkg::NUM_IN-1:0] prev_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  // Address phase capture
  wire addr_ok = hsel && hready && htrans[1];
  wire wr_go = addr_ok && hwrite;
  wire rd_go = addr_ok && !hwrite;
  // Write strobes decoded from the held address
  wire wr_ctrl = wr_pend_r && (wr_addr_r == psa_pkg::OFS_CTRL);
  wire wr_event = wr_pend_r && (wr_addr_r == psa_pkg::OFS_EVENT);
  wire alarm_reset_cmd = wr_ctrl && hwdata[psa_pkg::CTRL_ARESET_BIT];
  // Rising edges of loggable alarms; safety is excluded
  wire [6:0] ev_rise = deb_r[6:0] & ~prev_r[6:0];

  // Capture write address; answer every transfer with zero wait states
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_go;
      wr_addr_r <= haddr;
    end
  end

  // Control register; the reset bit is a self-clearing command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= psa_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= {28'h0000000, 1'b0, hwdata[2:0]};
    end
  end

  // Sticky event log: write-one-to-clear, new event wins the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_r <= 32'h0000_0000;
      prev_r <= '0;
    end else begin
      prev_r <= deb_r;
      event_r <= {25'h0000000, ev_rise |
                  (event_r[6:0] & ~(wr_event ? hwdata[6:0] : 7'h00))};
    end
  end

  // Read data mux chosen in address phase
  logic [31:0] rd_nxt;
  psa_pkg::psa_sev_t sev;
  psa_pkg::psa_seq_t seq_r;
  logic fault_r;
  always_comb begin
    case (haddr)
      psa_pkg::OFS_CTRL: rd_nxt = ctrl_r;
      psa_pkg::OFS_STATUS: rd_nxt = {24'h000000, 1'b0, fault_r, sev, 1'b0, seq_r};
      psa_pkg::OFS_EVENT: rd_nxt = event_r;
      psa_pkg::OFS_INPUTS: rd_nxt = {24'h000000, deb_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_go) begin
        hrdata <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm classification

  wire dual = ctrl_r[psa_pkg::CTRL_DUAL_BIT];
  wire manual = ctrl_r[psa_pkg::CTRL_MANUAL_BIT];
  wire on_cmd = ctrl_r[psa_pkg::CTRL_ON_BIT];
  wire safety = deb_r[psa_pkg::EV_SAFETY];
  wire mains = deb_r[psa_pkg::EV_MAINS];
  // Fuse is a whole series chain, so any open link shows as one alarm
  wire car_a = deb_r[psa_pkg::EV_FUSE_A] | deb_r[psa_pkg::EV_HEAT_A];
  wire car_b = deb_r[psa_pkg::EV_FUSE_B] | deb_r[psa_pkg::EV_HEAT_B];
  // Dual: one carriage down is only a warning; both down stops
  wire car_stop = dual ? (car_a & car_b) : (car_a | car_b);
  wire car_warn = dual & (car_a ^ car_b);
  wire hold = deb_r[psa_pkg::EV_AIR] | mains | car_stop;
  // Safety recovery gate: auto delay or manual button
  logic safe_hold_r;
  logic [11:0] safe_cnt_r;

  // Latched fault from blower protector
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (deb_r[psa_pkg::EV_BLOWER]) begin
      fault_r <= 1'b1;
    end else if (alarm_reset_cmd) begin
      fault_r <= 1'b0;
    end
  end

  // Severity, worst first
  assign sev = fault_r ? psa_pkg::PSA_SEV_FAULT :
               (hold || safe_hold_r) ? psa_pkg::PSA_SEV_WAIT :
               car_warn ? psa_pkg::PSA_SEV_WARN : psa_pkg::PSA_SEV_NONE;

  // Safety hold: released after 2 s (auto) or on button (manual)
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      safe_hold_r <= 1'b0;
      safe_cnt_r <= 12'h000;
    end else if (safety) begin
      safe_hold_r <= 1'b1;
      safe_cnt_r <= 12'h000;
    end else if (safe_hold_r) begin
      if (manual) begin
        if (btn_deb_r) safe_hold_r <= 1'b0;
      end else if (ms_tick_r) begin
        if (safe_cnt_r == 12'(psa_pkg::SAFETY_DELAY_MS - 1)) begin
          safe_hold_r <= 1'b0;
        end else begin
          safe_cnt_r <= safe_cnt_r + 12'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequencer

  wire run_ok = on_cmd && !fault_r && !hold && !safe_hold_r;
  logic [11:0] seq_cnt_r;
  psa_pkg::psa_seq_t seq_nxt;
  wire t_main = ms_tick_r && seq_cnt_r == 12'(psa_pkg::SOFT_TO_MAIN_MS - 1);
  wire t_rel = ms_tick_r && seq_cnt_r == 12'(psa_pkg::MAIN_TO_REL_MS - 1);

  always_comb begin
    case (seq_r)
      psa_pkg::PSA_OFF: seq_nxt = run_ok ? psa_pkg::PSA_SOFT : psa_pkg::PSA_OFF;
      psa_pkg::PSA_SOFT: seq_nxt = !run_ok ? psa_pkg::PSA_OFF :
                                   t_main ? psa_pkg::PSA_MAIN : psa_pkg::PSA_SOFT;
      psa_pkg::PSA_MAIN: seq_nxt = !run_ok ? psa_pkg::PSA_OFF :
                                   t_rel ? psa_pkg::PSA_RUN : psa_pkg::PSA_MAIN;
      psa_pkg::PSA_RUN: seq_nxt = run_ok ? psa_pkg::PSA_RUN : psa_pkg::PSA_OFF;
      default: seq_nxt = psa_pkg::PSA_OFF;
    endcase
  end

  // State and phase timer; timer restarts on each state change
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      seq_r <= psa_pkg::PSA_OFF;
      seq_cnt_r <= 12'h000;
    end else begin
      seq_r <= seq_nxt;
      if (seq_nxt != seq_r) begin
        seq_cnt_r <= 12'h000;
      end else if (ms_tick_r) begin
        seq_cnt_r <= seq_cnt_r + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Post-ventilation timer and outputs

  // Seconds counter on top of the ms tick; runs only while stopped
  logic [9:0] sec_ms_r;
  logic [8:0] blow_cnt_r;
  logic blow_r;
  wire sec_tick = ms_tick_r && sec_ms_r == 10'h3e7;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sec_ms_r <= 10'h000;
      blow_cnt_r <= 9'h000;
      blow_r <= 1'b0;
    end else if (seq_r != psa_pkg::PSA_OFF) begin
      sec_ms_r <= 10'h000;
      blow_cnt_r <= 9'h000;
      blow_r <= 1'b1;
    end else if (blow_r && ms_tick_r) begin
      sec_ms_r <= sec_tick ? 10'h000 : sec_ms_r + 10'h001;
      if (sec_tick) begin
        if (blow_cnt_r == 9'(BLOWER_S - 1)) begin
          blow_r <= 1'b0;
        end else begin
          blow_cnt_r <= blow_cnt_r + 9'h001;
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      outs <= '{feed_en: 1'b0, soft_k: 1'b0, main_k: 1'b0, blower_k: 1'b0,
                exciter_en: 1'b0, rf_mute_line: 1'b1, alarm_line_n: 1'b1,
                warn_led: 1'b0};
    end else begin
      outs.feed_en <= !safety;
      outs.exciter_en <= !mains;
      outs.soft_k <= !safety && (seq_nxt == psa_pkg::PSA_SOFT ||
                                 seq_nxt == psa_pkg::PSA_MAIN);
      outs.main_k <= !safety && (seq_nxt == psa_pkg::PSA_MAIN ||
                                 seq_nxt == psa_pkg::PSA_RUN);
      outs.blower_k <= blow_r || seq_nxt != psa_pkg::PSA_OFF;
      outs.rf_mute_line <= seq_nxt != psa_pkg::PSA_RUN;
      outs.alarm_line_n <= !(fault_r || hold || safety || car_warn);
      outs.warn_led <= car_warn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  a_safety_cut: assert property (@(posedge mclk) disable iff (!rst_n)
    safety |=> !outs.feed_en && !outs.soft_k && !outs.main_k)
    else $error("contactor feed not cut on emergency stop");
  a_exciter_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    safety && !mains |=> outs.exciter_en)
    else $error("exciter dropped on emergency stop");
  a_mains_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    mains |=> !outs.exciter_en && seq_r == psa_pkg::PSA_OFF)
    else $error("mains alarm did not stop");
  a_fault_latch: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_r && !alarm_reset_cmd |=> fault_r)
    else $error("fault cleared without reset command");
  a_safety_nolog: assert property (@(posedge mclk) disable iff (!rst_n)
    safety && ev_rise == 7'h00 && !wr_event |=> event_r == $past(event_r))
    else $error("safety logged");
  a_mains_log: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(deb_r[psa_pkg::EV_MAINS]) |=> event_r[psa_pkg::EV_MAINS])
    else $error("mains event not logged");
  a_hold_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    hold |=> seq_r == psa_pkg::PSA_OFF ##1 !outs.main_k)
    else $error("hold did not open contactors");
  a_warn_run: assert property (@(posedge mclk) disable iff (!rst_n)
    car_warn |=> outs.warn_led)
    else $error("warning lamp missing");
  a_alarm_line: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_r |=> !outs.alarm_line_n)
    else $error("alarm line not pulled");
  c_power_up: cover property (@(posedge mclk) seq_r == psa_pkg::PSA_RUN);
  c_fault_clear: cover property (@(posedge mclk) $fell(fault_r));
  c_safety_rel: cover property (@(posedge mclk) $fell(safe_hold_r));

endmodule

// ### psa_cu_model.sv
// Purpose: Control unit model that reaches the supervisor registers
// Assumes: One AHB-Lite slave whose hreadyout is the bus hready
// Notes: Single word transfers, one idle cycle between transfers
`timescale 1ns/1ps
module psa_cu_model (
  // Clock
  input wire logic mclk,
  // AHB-Lite master side
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  ////////////////////////////////////////////////////////////////
  // Bus idles at time zero, word size throughout
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////
  // One transfer; waits for hready with no limit, so only the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    // Released data lines must not keep looking valid
    hwdata <= ~wd;
  endtask

  ////////////////////////////////////////////////////////////////
  // Alarm reset command from the operator panel
  task automatic alarm_reset(input logic [31:0] ctrl);
    logic [31:0] rd;
    xfer(1'b1, psa_pkg::OFS_CTRL, ctrl | (32'h1 << psa_pkg::CTRL_ARESET_BIT), rd);
  endtask
endmodule

// ### psa_supervisor_bench.sv
// Purpose: Self-checking bench for the supply alarm supervisor
// Assumes: Shortened timing, 4 cycles per millisecond
// Notes: Pin vector order: safety, button, mains, air, blower, fuse a, heat a, fuse b, heat b
`timescale 1ns/1ps
module psa_supervisor_bench;
  // Shortened millisecond keeps the run short
  localparam int unsigned MSC = 4;
  localparam int unsigned T_SOFT = psa_pkg::SOFT_TO_MAIN_MS * MSC;
  localparam int unsigned T_MAIN = psa_pkg::MAIN_TO_REL_MS * MSC;
  localparam int unsigned T_SAFE = psa_pkg::SAFETY_DELAY_MS * MSC;
  localparam int unsigned T_BLOW = 3 * 1000 * MSC;
  // Bit positions in the packed output struct
  localparam int FEED = 7, SOFT = 6, MAIN = 5, BLOW = 4, EXC = 3, MUTE = 2, ALN = 1, WARN = 0;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [8:0] pin;
  psa_pkg::psa_out_t outs;
  logic [7:0] ov;
  int err_total, comparisons, cycles;
  assign ov = outs;

  psa_supervisor #(.DEB_MS(1), .BLOWER_S(3), .MS_CYC(MSC)) dut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .safety_alarm(pin[0]), .safety_reset_btn(pin[1]), .mains_alarm(pin[2]),
    .air_alarm(pin[3]), .blower_trip(pin[4]), .carriage_a_fuse(pin[5]),
    .carriage_a_overheat(pin[6]), .carriage_b_fuse(pin[7]),
    .carriage_b_overheat(pin[8]), .outs(outs));
  psa_cu_model cu (
    .mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  ////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      err_total++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Longer than synchroniser plus debounce
  task automatic settle();
    cyc(40);
  endtask
  task automatic wait_out(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (ov[b] !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(ov[b]), 32'(v));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    cu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    cu.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    cyc(5);
    chk(32'(ov), 32'h8e);
    chk(32'({hreadyout, hresp}), 32'h2);
    rd_chk(psa_pkg::OFS_CTRL, 32'hffff_ffff, psa_pkg::CTRL_RESET);
    rd_chk(8'h40, 32'hffff_ffff, 32'h0);
    rd_chk(psa_pkg::OFS_EVENT, 32'hff, 32'h0);
  endtask
  task automatic t_powerup();
    wr(psa_pkg::OFS_CTRL, 32'h1);
    wait_out(SOFT, 1'b1, 20);
    cyc(T_SOFT - 40);
    chk(32'(ov[MAIN]), 32'h0);
    wait_out(MAIN, 1'b1, 80);
    chk(32'(ov[BLOW]), 32'h1);
    cyc(T_MAIN - 80);
    chk(32'(ov[SOFT]), 32'h1);
    wait_out(SOFT, 1'b0, 120);
    wait_out(MUTE, 1'b0, 10);
    rd_chk(psa_pkg::OFS_STATUS, 32'h7, 32'h3);
  endtask
  // Dual carriage: a fuse only warns, an air fault still holds
  task automatic t_dual();
    wr(psa_pkg::OFS_CTRL, 32'h3);
    pin[5] <= 1'b1;
    settle();
    chk(32'({ov[MAIN], ov[WARN]}), 32'h3);
    rd_chk(psa_pkg::OFS_STATUS, 32'h30, 32'h10);
    rd_chk(psa_pkg::OFS_INPUTS, 32'h8, 32'h8);
    pin[3] <= 1'b1;
    settle();
    rd_chk(psa_pkg::OFS_STATUS, 32'h30, 32'h20);
    pin[3] <= 1'b0;
    pin[5] <= 1'b0;
    wr(psa_pkg::OFS_CTRL, 32'h1);
    wr(psa_pkg::OFS_EVENT, 32'h7f);
    wait_out(SOFT, 1'b1, 200);
  endtask
  // Temporary hold: stop, log, restart alone
  task automatic t_temp(input int p, input int ev, input logic exc_off);
    pin[p] <= 1'b1;
    settle();
    chk(32'({ov[SOFT], ov[MAIN], ov[ALN]}), 32'h0);
    if (exc_off) chk(32'(ov[EXC]), 32'h0);
    rd_chk(psa_pkg::OFS_EVENT, 32'h1 << ev, 32'h1 << ev);
    rd_chk(psa_pkg::OFS_INPUTS, 32'h1 << ev, 32'h1 << ev);
    pin[p] <= 1'b0;
    wr(psa_pkg::OFS_EVENT, 32'h7f);
    wait_out(SOFT, 1'b1, 200);
  endtask
  // Single carriage fuse chain stops the set
  task automatic t_fuse(input int p, input int ev);
    pin[p] <= 1'b1;
    settle();
    chk(32'({ov[SOFT], ov[MAIN], ov[ALN]}), 32'h0);
    rd_chk(psa_pkg::OFS_INPUTS, 32'h1 << ev, 32'h1 << ev);
    pin[p] <= 1'b0;
    settle();
    cu.alarm_reset(32'h1);
    wr(psa_pkg::OFS_EVENT, 32'h7f);
    wait_out(SOFT, 1'b1, 200);
  endtask
  task automatic t_blower();
    pin[4] <= 1'b1;
    settle();
    chk(32'({ov[SOFT], ov[MAIN]}), 32'h0);
    rd_chk(psa_pkg::OFS_STATUS, 32'h70, 32'h70);
    rd_chk(psa_pkg::OFS_EVENT, 32'h4, 32'h4);
    // Reset while the protector is still tripped must not clear
    cu.alarm_reset(32'h1);
    pin[4] <= 1'b0;
    settle();
    cyc(200);
    chk(32'(ov[SOFT]), 32'h0);
    cu.alarm_reset(32'h1);
    wr(psa_pkg::OFS_EVENT, 32'h7f);
    wait_out(SOFT, 1'b1, 200);
  endtask
  task automatic t_safety(input logic manual);
    wr(psa_pkg::OFS_CTRL, manual ? 32'h5 : 32'h1);
    pin[0] <= 1'b1;
    settle();
    chk(32'({ov[FEED], ov[SOFT], ov[MAIN]}), 32'h0);
    chk(32'({ov[EXC], ov[ALN]}), 32'h2);
    rd_chk(psa_pkg::OFS_EVENT, 32'hff, 32'h0);
    rd_chk(psa_pkg::OFS_INPUTS, 32'h80, 32'h80);
    pin[0] <= 1'b0;
    settle();
    cyc(T_SAFE - 100);
    chk(32'(ov[SOFT]), 32'h0);
    if (manual) begin
      cyc(400);
      chk(32'(ov[SOFT]), 32'h0);
      pin[1] <= 1'b1;
      settle();
      pin[1] <= 1'b0;
      wait_out(SOFT, 1'b1, 100);
    end else begin
      wait_out(SOFT, 1'b1, 300);
    end
  endtask
  // Blower keeps running after a commanded stop
  task automatic t_postrun();
    wr(psa_pkg::OFS_CTRL, 32'h0);
    wait_out(SOFT, 1'b0, 20);
    cyc(T_BLOW - 100);
    chk(32'(ov[BLOW]), 32'h1);
    wait_out(BLOW, 1'b0, 200);
    chk(32'(ov[MUTE]), 32'h1);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    pin = 9'h000;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_powerup();
    t_dual();
    t_temp(2, psa_pkg::EV_MAINS, 1'b1);
    t_temp(3, psa_pkg::EV_AIR, 1'b0);
    t_temp(6, psa_pkg::EV_HEAT_A, 1'b0);
    t_temp(8, psa_pkg::EV_HEAT_B, 1'b0);
    t_fuse(5, psa_pkg::EV_FUSE_A);
    t_fuse(7, psa_pkg::EV_FUSE_B);
    t_blower();
    t_safety(1'b0);
    t_safety(1'b1);
    t_postrun();
    stop_test();
  end
endmodule
